/* verilog/occl_consts.svh */
`ifndef OCCL_CONSTS_SVH
`define OCCL_CONSTS_SVH

// Register offsets on the byte register port
`define OCCL_ADDR_HIGH_CODE 8'h10
`define OCCL_ADDR_LOW_CODE 8'h11
`define OCCL_ADDR_LIMITS 8'h1E

// Field layout of the limits register
`define OCCL_LIM_UPPER_MSB 7
`define OCCL_LIM_UPPER_LSB 4
`define OCCL_LIM_LOWER_MSB 3
`define OCCL_LIM_LOWER_LSB 0

// Tails appended to each limit nibble
`define OCCL_UPPER_TAIL 3'h7
`define OCCL_LOWER_TAIL 3'h0

// Reset values
`define OCCL_LIMITS_RESET 8'hF0
`define OCCL_HIGH_CODE_RESET 7'h40
`define OCCL_LOW_CODE_RESET 7'h20

// Answer for an unmapped read
`define OCCL_UNMAPPED_READ 8'h00

`endif

/* verilog/occl_pkg.sv */
package occl_pkg;
  typedef logic [6:0] occl_code_t;
  typedef logic [3:0] occl_nibble_t;
  typedef logic [7:0] occl_byte_t;
  typedef logic [7:0] occl_addr_t;
endpackage : occl_pkg

/* verilog/occl_clamp.sv */
`timescale 1ns/10ps
`include "occl_consts.svh"
module occl_clamp (
  // Code in
  input wire occl_pkg::occl_code_t code_i,
  // Limit nibbles
  input wire occl_pkg::occl_nibble_t upper_i,
  input wire occl_pkg::occl_nibble_t lower_i,
  // Result
  output occl_pkg::occl_code_t code_o,
  output logic above_o,
  output logic below_o
);
  import occl_pkg::*;

  occl_code_t upper_code;
  occl_code_t lower_code;

  always_comb begin
    upper_code = {upper_i, `OCCL_UPPER_TAIL};
    lower_code = {lower_i, `OCCL_LOWER_TAIL};
    // Unsigned compare on plain logic vectors
    above_o = (code_i > upper_code);
    below_o = (code_i < lower_code);
    // Upper cap checked first; with crossed limits a code above the cap yields the upper value, any other the lower
    if (above_o) begin
      code_o = upper_code;
    end else if (below_o) begin
      code_o = lower_code;
    end else begin
      code_o = code_i;
    end
  end
endmodule : occl_clamp

/* verilog/occl_top.sv */
`timescale 1ns/10ps
`include "occl_consts.svh"
module occl_top #(
  parameter occl_pkg::occl_code_t HIGH_CODE_RESET = `OCCL_HIGH_CODE_RESET,
  parameter occl_pkg::occl_code_t LOW_CODE_RESET = `OCCL_LOW_CODE_RESET,
  parameter occl_pkg::occl_byte_t LIMITS_RESET = `OCCL_LIMITS_RESET
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Voltage select pin
  input wire logic level_select_pin_i,
  // Byte register port
  input wire occl_pkg::occl_addr_t reg_addr_i,
  input wire occl_pkg::occl_byte_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output occl_pkg::occl_byte_t reg_rdata_o,
  output logic reg_rvalid_o,
  // Effective code and status
  output occl_pkg::occl_code_t eff_code_o,
  output logic clamped_high_o,
  output logic clamped_low_o,
  output logic limits_crossed_o,
  output logic code_change_o
);
  import occl_pkg::*;

  // Register state
  occl_code_t high_code_ff;
  occl_code_t nxt_high_code;
  occl_code_t low_code_ff;
  occl_code_t nxt_low_code;
  occl_byte_t limits_ff;
  occl_byte_t nxt_limits;

  // Read answer state
  occl_byte_t rdata_ff;
  occl_byte_t nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;

  // Change tracking state
  occl_code_t last_code_ff;
  occl_code_t nxt_last_code;
  logic change_ff;
  logic nxt_change;

  // Clamp results
  occl_nibble_t upper_nib;
  occl_nibble_t lower_nib;
  occl_code_t high_eff;
  occl_code_t low_eff;
  logic high_above;
  logic high_below;
  logic low_above;
  logic low_below;

  // Register writes
  always_comb begin
    nxt_high_code = high_code_ff;
    nxt_low_code = low_code_ff;
    nxt_limits = limits_ff;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `OCCL_ADDR_HIGH_CODE: nxt_high_code = reg_wdata_i[6:0];
        `OCCL_ADDR_LOW_CODE: nxt_low_code = reg_wdata_i[6:0];
        `OCCL_ADDR_LIMITS: nxt_limits = reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      high_code_ff <= HIGH_CODE_RESET;
      low_code_ff <= LOW_CODE_RESET;
      limits_ff <= LIMITS_RESET;
    end else begin
      high_code_ff <= nxt_high_code;
      low_code_ff <= nxt_low_code;
      limits_ff <= nxt_limits;
    end
  end

  // Register reads; bit 7 of code registers reads zero
  always_comb begin
    nxt_rvalid = reg_rd_i;
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `OCCL_ADDR_HIGH_CODE: nxt_rdata = {1'b0, high_code_ff};
        `OCCL_ADDR_LOW_CODE: nxt_rdata = {1'b0, low_code_ff};
        `OCCL_ADDR_LIMITS: nxt_rdata = limits_ff;
        default: nxt_rdata = `OCCL_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;

  // Limit fields
  assign upper_nib = limits_ff[`OCCL_LIM_UPPER_MSB:`OCCL_LIM_UPPER_LSB];
  assign lower_nib = limits_ff[`OCCL_LIM_LOWER_MSB:`OCCL_LIM_LOWER_LSB];

  // Both codes clamped in parallel so the pin switch is a pure mux
  occl_clamp u_clamp_high (
    .code_i(high_code_ff),
    .upper_i(upper_nib),
    .lower_i(lower_nib),
    .code_o(high_eff),
    .above_o(high_above),
    .below_o(high_below)
  );

  occl_clamp u_clamp_low (
    .code_i(low_code_ff),
    .upper_i(upper_nib),
    .lower_i(lower_nib),
    .code_o(low_eff),
    .above_o(low_above),
    .below_o(low_below)
  );

  // No register on this path: the pin must switch the code at once
  always_comb begin
    if (level_select_pin_i) begin
      eff_code_o = high_eff;
      clamped_high_o = high_above;
      clamped_low_o = high_below & ~high_above;
    end else begin
      eff_code_o = low_eff;
      clamped_high_o = low_above;
      clamped_low_o = low_below & ~low_above;
    end
  end

  assign limits_crossed_o = ({lower_nib, `OCCL_LOWER_TAIL} > {upper_nib, `OCCL_UPPER_TAIL});

  // One-cycle pulse when the effective code moves
  always_comb begin
    nxt_last_code = eff_code_o;
    nxt_change = (eff_code_o != last_code_ff);
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_code_ff <= LOW_CODE_RESET;
      change_ff <= 1'b0;
    end else begin
      last_code_ff <= nxt_last_code;
      change_ff <= nxt_change;
    end
  end

  assign code_change_o = change_ff;
endmodule : occl_top

/* test/occl_top_asserts.sv */
`timescale 1ns/10ps
`include "occl_consts.svh"
module occl_chk (
  // Clock, reset, register writes
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire occl_pkg::occl_addr_t reg_addr_i,
  input wire occl_pkg::occl_byte_t reg_wdata_i,
  input wire logic reg_wr_i,
  // Watched outputs
  input wire occl_pkg::occl_code_t eff_code_o,
  input wire logic clamped_high_o,
  input wire logic clamped_low_o,
  input wire logic limits_crossed_o,
  input wire logic code_change_o
);
  import occl_pkg::*;
  occl_byte_t lim_ff;
  occl_byte_t nxt_lim;
  occl_code_t up;
  occl_code_t lo;
  always_comb begin
    nxt_lim = (reg_wr_i && reg_addr_i == `OCCL_ADDR_LIMITS) ? reg_wdata_i : lim_ff;
  end
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) lim_ff <= `OCCL_LIMITS_RESET;
    else lim_ff <= nxt_lim;
  end
  assign up = {lim_ff[7:4], 3'h7};
  assign lo = {lim_ff[3:0], 3'h0};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // A crossed floor may lift the code past the cap, so the floor case is exempt
  upper_cap_a: assert property (!clamped_low_o |-> eff_code_o <= up)
    else $error("code above cap");
  clamp_excl_a: assert property (!(clamped_high_o && clamped_low_o))
    else $error("both clamp flags set");
  high_clamp_a: assert property (clamped_high_o |-> eff_code_o == up)
    else $error("high clamp value");
  low_clamp_a: assert property (clamped_low_o |-> eff_code_o == lo)
    else $error("low clamp value");
  floor_hold_a: assert property (!limits_crossed_o |-> eff_code_o >= lo)
    else $error("code below floor");
  crossed_flag_a: assert property (limits_crossed_o == (lim_ff[3:0] > lim_ff[7:4]))
    else $error("crossed flag");
  change_pulse_a: assert property ($changed(eff_code_o) |=> code_change_o)
    else $error("no change pulse");
  change_quiet_a: assert property (!$changed(eff_code_o) |=> !code_change_o)
    else $error("spurious change pulse");
  cover property (clamped_high_o);
  cover property (clamped_low_o);
  cover property (limits_crossed_o);
  cover property (code_change_o);
endmodule : occl_chk
bind occl_top occl_chk occl_chk_i (.*);

/* test/tb_occl_top.sv */
`timescale 1ns/10ps
module tb_occl_top;
  import occl_pkg::*;
  logic ref_clk_i = 0;
  logic sys_rst_i = 1;
  logic pin = 0;
  logic wr = 0;
  logic rd = 0;
  occl_addr_t addr = 8'h00;
  occl_byte_t wdata = 8'h00;
  occl_byte_t rdata;
  logic rvalid;
  occl_code_t eff;
  occl_byte_t lim = 8'hF0;
  occl_code_t hc = 7'h40;
  occl_code_t lc = 7'h20;
  occl_byte_t eq[$];
  occl_byte_t rq[$];
  occl_addr_t tab[4] = '{8'h10, 8'h11, 8'h1E, 8'h1F};
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  occl_top occl_top_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .level_select_pin_i(pin), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .eff_code_o(eff),
    .clamped_high_o(), .clamped_low_o(), .limits_crossed_o(), .code_change_o());
  task end_sim;
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task chk(input occl_byte_t seen, input occl_byte_t exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic occl_byte_t clamp(input occl_code_t c);
    occl_code_t up;
    occl_code_t lo;
    up = {lim[7:4], 3'h7};
    lo = {lim[3:0], 3'h0};
    if (c > up) return {1'b0, up};
    if (c < lo) return {1'b0, lo};
    return {1'b0, c};
  endfunction : clamp
  task cyc(input occl_addr_t a, input occl_byte_t d, input logic w, input logic r);
    @(negedge ref_clk_i);
    addr = a;
    wdata = d;
    wr = w;
    rd = r;
    pin = $urandom % 2;
    // Read of the same cycle sees the old value
    if (r) rq.push_back(a == 8'h10 ? {1'b0, hc} : a == 8'h11 ? {1'b0, lc} :
      a == 8'h1E ? lim : 8'h00);
    if (w && a == 8'h10) hc = d[6:0];
    if (w && a == 8'h11) lc = d[6:0];
    if (w && a == 8'h1E) lim = d;
    eq.push_back(clamp(pin ? hc : lc));
  endtask : cyc
  always @(posedge ref_clk_i) begin
    #1;
    if (eq.size() > 0) chk({1'b0, eff}, eq.pop_front());
    if (rvalid === 1'b1) chk(rdata, rq.pop_front());
    cycles++;
    if (cycles > 2000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(63));
    repeat (5) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    sys_rst_i = 0;
    for (int k = 0; k < 4; k++) cyc(tab[k], 8'h00, 1'b0, 1'b1);
    for (int i = 0; i < 400; i++) cyc(tab[$urandom % 4], $urandom, $urandom % 2, $urandom % 2);
    cyc(8'h00, 8'h00, 1'b0, 1'b0);
    @(negedge ref_clk_i);
    rd = 0;
    wr = 0;
    repeat (2) @(posedge ref_clk_i);
    end_sim();
  end
endmodule : tb_occl_top
